// ==== design/tmr_pkg.sv ====
// Shared constants for the match and capture timer block.
package tmr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_UNITS = 6;           // Timer units per device.
  localparam int unsigned NCH       = 4;           // Match and capture channels.
  localparam int unsigned CLK_HZ    = 40_000_000;  // Bus clock rate.

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_COUNT  = 8'h04;
  localparam logic [7:0] A_PLIM   = 8'h08;
  localparam logic [7:0] A_PCNT   = 8'h0c;
  localparam logic [7:0] A_MCTL   = 8'h10;
  localparam logic [7:0] A_CCTL   = 8'h14;
  localparam logic [7:0] A_EXT    = 8'h18;
  localparam logic [7:0] A_STAT   = 8'h1c;
  localparam logic [7:0] A_MASK   = 8'h20;
  localparam logic [7:0] A_MATCH0 = 8'h24;
  localparam logic [7:0] A_CAPT0  = 8'h34;
  localparam logic [7:0] A_STEP   = 8'h04;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int unsigned C_EN     = 0;  // Count enable.
  localparam int unsigned C_RST    = 1;  // Hold counters at zero.
  localparam int unsigned C_MODE   = 2;  // 0 timer, 1 counter.
  localparam int unsigned C_EDGE   = 3;  // Two bits, count_edge_e.
  localparam int unsigned CTRL_W   = 5;
  localparam int unsigned STRIDE   = 3;  // Bits per channel in MCTL and CCTL.
  localparam int unsigned MC_INT   = 0;
  localparam int unsigned MC_RST   = 1;
  localparam int unsigned MC_STOP  = 2;
  localparam int unsigned CC_RISE  = 0;
  localparam int unsigned CC_FALL  = 1;
  localparam int unsigned CC_INT   = 2;
  localparam int unsigned CFG_W    = 12;
  localparam int unsigned EXT_ACT  = 4;  // Action fields start here.
  localparam int unsigned ST_CAP   = 4;  // Capture flags start here.
  localparam int unsigned ST_W     = 8;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } count_edge_e;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_CLR  = 2'b01,
    ACT_SET  = 2'b10,
    ACT_TGL  = 2'b11
  } ext_act_e;

endpackage

// ==== design/edge_sync.sv ====
// Two-flop synchroniser with edge detection for pin inputs.
module edge_sync #(
  parameter int unsigned W = 1 // Number of pins.
)(
  input  wire logic         clk,   // Bus clock.
  input  wire logic         rst_b, // Asynchronous reset, active low.
  input  wire logic [W-1:0] pin,   // Asynchronous pin levels.
  output logic      [W-1:0] rise,  // One-cycle pulse on a rising edge.
  output logic      [W-1:0] fall   // One-cycle pulse on a falling edge.
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // A zero width would leave no pins to watch.
  if (W < 1) begin : g_bad_width
    $error("synchroniser width must be at least one");
  end

  // The first stage feeds only the second; edges come from later stages.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge pulses from the settled stages.
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

endmodule

// ==== design/prescale_div.sv ====
// Programmable prescaler that turns source ticks into count advances.
module prescale_div #(
  parameter int unsigned W = 32 // Prescaler width.
)(
  input  wire logic         clk,     // Bus clock.
  input  wire logic         rst_b,   // Asynchronous reset, active low.
  input  wire logic         tick,    // One source cycle.
  input  wire logic         clear,   // Hold the prescaler at zero.
  input  wire logic [W-1:0] limit,   // Terminal value.
  output logic              adv,     // Advance the main count this cycle.
  output logic      [W-1:0] count_q  // Present prescaler value.
);

  logic [W-1:0] count_d;

  // A zero-width prescaler could never reach its limit, so it is refused here.
  if (W < 1) begin : g_bad_width
    $error("prescaler width must be at least one");
  end

  // A limit of zero gives an advance on every tick.
  assign adv = tick & ~clear & (count_q == limit);

  // Wrap to zero at the limit, otherwise step on each tick.
  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = '0;
    end else if (adv) begin
      count_d = '0;
    end else if (tick) begin
      count_d = count_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ==== design/timer_counter_match_capture.sv ====
// Timer unit with prescaler, four match channels and four capture channels.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
module timer_counter_match_capture
  import tmr_pkg::*;
#(
  parameter int unsigned UNIT_ID = 0 // Position among the timer units.
)(
  input  wire logic        clk,                 // Bus clock, 40 MHz.
  input  wire logic        rst_b,               // Asynchronous reset, active low.
  input  wire logic        wb_cyc_i,            // Wishbone cycle.
  input  wire logic        wb_stb_i,            // Wishbone strobe.
  input  wire logic        wb_we_i,             // Wishbone write.
  input  wire logic [7:0]  wb_adr_i,            // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,            // Wishbone byte lanes.
  input  wire logic [31:0] wb_dat_i,            // Wishbone write data.
  output logic      [31:0] wb_dat_o,            // Wishbone read data.
  output logic             wb_ack_o,            // Wishbone acknowledge.
  input  wire logic        count_input,         // External count source pin.
  input  wire logic        capture_input_zero,  // Capture pin 0.
  input  wire logic        capture_input_one,   // Capture pin 1.
  input  wire logic        capture_input_two,   // Capture pin 2.
  input  wire logic        capture_input_three, // Capture pin 3.
  output logic             match_output_zero,   // Match pin 0.
  output logic             match_output_one,    // Match pin 1.
  output logic             match_output_two,    // Match pin 2.
  output logic             match_output_three,  // Match pin 3.
  output logic             irq                  // Level interrupt.
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Six units share one decode in the system; an index past them is refused.
  if (UNIT_ID >= NUM_UNITS) begin : g_bad_unit
    $error("UNIT_ID exceeds the number of timer units");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge write data into a register by byte lane.
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Byte address of channel register ch in a bank starting at base.
  function automatic logic [7:0] chan_adr(input logic [7:0] base, input int unsigned ch);
    return base + 8'(A_STEP * ch);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NCH-1:0] cap_rise;
  logic [NCH-1:0] cap_fall;
  logic           cnt_rise;
  logic           cnt_fall;

  edge_sync #(.W(NCH)) u_cap_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   ({capture_input_three, capture_input_two, capture_input_one, capture_input_zero}),
    .rise  (cap_rise),
    .fall  (cap_fall)
  );

  edge_sync #(.W(1)) u_cnt_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (count_input),
    .rise  (cnt_rise),
    .fall  (cnt_fall)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q,  ctrl_d;
  logic [31:0]       tc_q,    tc_d;
  logic [31:0]       plim_q,  plim_d;
  logic [CFG_W-1:0]  mctl_q,  mctl_d;
  logic [CFG_W-1:0]  cctl_q,  cctl_d;
  logic [CFG_W-1:0]  ext_q,   ext_d;
  logic [ST_W-1:0]   stat_q,  stat_d;
  logic [ST_W-1:0]   mask_q,  mask_d;
  logic [31:0]       mr_q   [NCH];
  logic [31:0]       mr_d   [NCH];
  logic [31:0]       cap_q  [NCH];
  logic [31:0]       cap_d  [NCH];
  logic              irq_d;
  logic              ack_q,   ack_d;
  logic [31:0]       dat_q,   dat_d;
  logic [31:0]       pcnt;
  logic              adv;
  logic              src_tick;
  logic [NCH-1:0]    mhit;
  logic [NCH-1:0]    cev;
  logic [NCH-1:0]    hit_rst;
  logic [NCH-1:0]    hit_stop;
  logic              wr;
  logic              rd;
  logic [7:0]        word;

  // Bus access is committed at the edge where the master sees ack high.
  assign word = {wb_adr_i[7:2], 2'b00};
  assign wr   = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
  assign rd   = wb_cyc_i & wb_stb_i & ack_q & ~wb_we_i;

  // Timer mode ticks every clock; counter mode ticks on the chosen pin edge.
  always_comb begin
    src_tick = 1'b1;
    if (ctrl_q[C_MODE]) begin
      unique case (count_edge_e'(ctrl_q[C_EDGE +: 2]))
        EDGE_RISE: src_tick = cnt_rise;
        EDGE_FALL: src_tick = cnt_fall;
        EDGE_BOTH: src_tick = cnt_rise | cnt_fall;
        EDGE_OFF:  src_tick = 1'b0;
      endcase
    end
  end

  prescale_div #(.W(32)) u_pre (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick    (src_tick & ctrl_q[C_EN]),
    .clear   (ctrl_q[C_RST]),
    .limit   (plim_q),
    .adv     (adv),
    .count_q (pcnt)
  );

  // Match and capture events.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      mhit[i] = adv & (tc_q == mr_q[i]);
      hit_rst[i]  = mhit[i] & mctl_q[STRIDE*i + MC_RST];
      hit_stop[i] = mhit[i] & mctl_q[STRIDE*i + MC_STOP];
      cev[i]  = (cctl_q[STRIDE*i + CC_RISE] & cap_rise[i]) |
                (cctl_q[STRIDE*i + CC_FALL] & cap_fall[i]);
    end
  end

  // ----------------------------------------------------------------
  // Timer core next state
  // ----------------------------------------------------------------
  // Count and output events go first and software writes override them; flag sets
  // come last, so a flag set in the same cycle as its clear survives.
  always_comb begin
    ctrl_d = ctrl_q;
    tc_d   = tc_q;
    plim_d = plim_q;
    mctl_d = mctl_q;
    cctl_d = cctl_q;
    ext_d  = ext_q;
    stat_d = stat_q;
    mask_d = mask_q;
    mr_d   = mr_q;
    cap_d  = cap_q;
    if (adv) begin
      tc_d = tc_q + 32'h0000_0001;
    end
    for (int i = 0; i < NCH; i++) begin
      if (hit_rst[i]) begin
        tc_d = ZERO32;
      end
      if (hit_stop[i]) begin
        tc_d            = tc_q;
        ctrl_d[C_EN]    = 1'b0;
      end
      if (mhit[i]) begin
        unique case (ext_act_e'(ext_q[EXT_ACT + 2*i +: 2]))
          ACT_NONE: ext_d[i] = ext_q[i];
          ACT_CLR:  ext_d[i] = 1'b0;
          ACT_SET:  ext_d[i] = 1'b1;
          ACT_TGL:  ext_d[i] = ~ext_q[i];
        endcase
      end
      if (cev[i]) begin
        cap_d[i] = tc_q;
      end
    end
    if (ctrl_q[C_RST]) begin
      tc_d = ZERO32;
    end
    // A read clears only the flags it returned, so a flag set after the snapshot survives.
    if (rd && word == A_STAT) begin
      stat_d = stat_q & ~dat_q[ST_W-1:0];
    end
    if (wr) begin
      if (word == A_CTRL)  ctrl_d = CTRL_W'(lanes(32'(ctrl_q), wb_dat_i, wb_sel_i));
      if (word == A_COUNT) tc_d   = lanes(tc_q, wb_dat_i, wb_sel_i);
      if (word == A_PLIM)  plim_d = lanes(plim_q, wb_dat_i, wb_sel_i);
      if (word == A_MCTL)  mctl_d = CFG_W'(lanes(32'(mctl_q), wb_dat_i, wb_sel_i));
      if (word == A_CCTL)  cctl_d = CFG_W'(lanes(32'(cctl_q), wb_dat_i, wb_sel_i));
      if (word == A_EXT)   ext_d  = CFG_W'(lanes(32'(ext_q), wb_dat_i, wb_sel_i));
      if (word == A_MASK)  mask_d = ST_W'(lanes(32'(mask_q), wb_dat_i, wb_sel_i));
      if (word == A_STAT && wb_sel_i[0]) stat_d = stat_q & ~wb_dat_i[ST_W-1:0];
      for (int i = 0; i < NCH; i++) begin
        if (word == chan_adr(A_MATCH0, i)) mr_d[i] = lanes(mr_q[i], wb_dat_i, wb_sel_i);
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (mhit[i] && mctl_q[STRIDE*i + MC_INT]) stat_d[i] = 1'b1;
      if (cev[i] && cctl_q[STRIDE*i + CC_INT]) stat_d[ST_CAP + i] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= '0;
      tc_q   <= ZERO32;
      plim_q <= ZERO32;
      mctl_q <= '0;
      cctl_q <= '0;
      ext_q  <= '0;
      stat_q <= '0;
      mask_q <= '0;
      irq    <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        mr_q[i]  <= ZERO32;
        cap_q[i] <= ZERO32;
      end
    end else begin
      ctrl_q <= ctrl_d;
      tc_q   <= tc_d;
      plim_q <= plim_d;
      mctl_q <= mctl_d;
      cctl_q <= cctl_d;
      ext_q  <= ext_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq    <= irq_d;
      mr_q   <= mr_d;
      cap_q  <= cap_d;
    end
  end

  // Match pins come straight from the output state flops.
  assign match_output_zero  = ext_q[0];
  assign match_output_one   = ext_q[1];
  assign match_output_two   = ext_q[2];
  assign match_output_three = ext_q[3];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state; unmapped words answer with zero so the bus never hangs.
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    dat_d = ZERO32;
    unique case (word)
      A_CTRL:  dat_d = 32'(ctrl_q);
      A_COUNT: dat_d = tc_q;
      A_PLIM:  dat_d = plim_q;
      A_PCNT:  dat_d = pcnt;
      A_MCTL:  dat_d = 32'(mctl_q);
      A_CCTL:  dat_d = 32'(cctl_q);
      A_EXT:   dat_d = 32'(ext_q);
      A_STAT:  dat_d = 32'(stat_q);
      A_MASK:  dat_d = 32'(mask_q);
      default: dat_d = ZERO32;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (word == chan_adr(A_MATCH0, i)) dat_d = mr_q[i];
      if (word == chan_adr(A_CAPT0, i))  dat_d = cap_q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      dat_q <= ZERO32;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence plain_adv_s;
    adv && !ctrl_q[C_RST] && !wr && !(|hit_rst) && !(|hit_stop);
  endsequence

  sequence cap0_evt_s;
    cctl_q[CC_RISE] && cap_rise[0];
  endsequence

  count_step_a: assert property (plain_adv_s |=> tc_q == $past(tc_q) + 32'h0000_0001)
    else $error("count did not step by one on an advance");
  pre_wrap_a: assert property (adv && !ctrl_q[C_RST] |=> pcnt == ZERO32)
    else $error("prescaler did not restart after its limit");
  timer_tick_a: assert property (ctrl_q[C_EN] && !ctrl_q[C_MODE] && !ctrl_q[C_RST] && plim_q == ZERO32 |-> adv)
    else $error("timer mode with zero limit missed an advance");
  match_reset_a: assert property (hit_rst[1] && !(|hit_stop) && !wr && !ctrl_q[C_RST] |=> tc_q == ZERO32)
    else $error("reset match did not clear the count");
  match_stop_a: assert property (hit_stop[0] && !wr |=> !ctrl_q[C_EN] && tc_q == $past(tc_q) ##1 !adv)
    else $error("stop match did not halt the count");
  match_flag_a: assert property (mhit[2] && mctl_q[2*STRIDE + MC_INT] |=> stat_q[2])
    else $error("match flag was not set");
  capture_latch_a: assert property (cap0_evt_s |=> cap_q[0] == $past(tc_q))
    else $error("capture did not latch the count");
  capture_quiet_a: assert property (cev[3] && !cctl_q[3*STRIDE + CC_INT] && !stat_q[ST_CAP + 3]
                                    |=> !stat_q[ST_CAP + 3])
    else $error("capture flagged with its interrupt disabled");
  out_toggle_a: assert property (mhit[1] && ext_q[EXT_ACT + 2 +: 2] == ACT_TGL && !wr
                                 |=> match_output_one != $past(match_output_one))
    else $error("match output did not toggle");
  flag_hold_a: assert property (stat_q[0] && !(wr && word == A_STAT) && !(rd && word == A_STAT)
                                |=> stat_q[0])
    else $error("status flag dropped without a clear");
  irq_level_a: assert property (irq == |(stat_q & mask_q))
    else $error("interrupt level disagrees with the unmasked flags");

endmodule

// ==== tb/tmr_pins.sv ====
// Pin-side model of the timer: drives count and capture pins, watches match pins.
module tmr_pins (
  input  wire logic       clk,                 // Bench clock.
  output logic            count_input,         // External count source.
  output logic            capture_input_zero,  // Capture pin 0.
  output logic            capture_input_one,   // Capture pin 1.
  output logic            capture_input_two,   // Capture pin 2.
  output logic            capture_input_three, // Capture pin 3.
  input  wire logic       match_output_zero,   // Match pin 0.
  input  wire logic       match_output_one,    // Match pin 1.
  input  wire logic       match_output_two,    // Match pin 2.
  input  wire logic       match_output_three,  // Match pin 3.
  output logic      [3:0] pin_view             // Match pins gathered, pin 0 in bit 0.
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cap_q; // Capture pin levels.

  // Pins idle low and only ever change just after a clock edge.
  initial begin
    count_input = 1'b0;
    cap_q = 4'h0;
  end
  assign capture_input_zero  = cap_q[0];
  assign capture_input_one   = cap_q[1];
  assign capture_input_two   = cap_q[2];
  assign capture_input_three = cap_q[3];
  assign pin_view = {match_output_three, match_output_two, match_output_one, match_output_zero};

  // Five clocks per level, so the synchroniser sees every edge even when slow.
  task automatic pulse_count(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (5) @(posedge clk);
      count_input <= 1'b1;
      repeat (5) @(posedge clk);
      count_input <= 1'b0;
    end
  endtask

  // One pin change per call; a caller makes a pulse with two calls.
  task automatic set_cap(input int ch, input logic v);
    @(posedge clk);
    cap_q[ch] <= v;
  endtask
endmodule

// ==== tb/timer_counter_match_capture_tb.sv ====
// Self-checking bench for the match and capture timer.
`define CHK(what, xp, got) begin n_tests++; if ((got) !== (xp)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", what, xp, got); end end
module timer_counter_match_capture_tb
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, pin_view;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        count_input, cap0, cap1, cap2, cap3, m0, m1, m2, m3;
  int          err_total;
  int          n_tests;

  // 40 MHz clock.
  always #12.5 clk = ~clk;

  timer_counter_match_capture dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .count_input(count_input), .capture_input_zero(cap0), .capture_input_one(cap1),
    .capture_input_two(cap2), .capture_input_three(cap3), .match_output_zero(m0), .match_output_one(m1),
    .match_output_two(m2), .match_output_three(m3), .irq(irq));
  tmr_pins ext (.clk(clk), .count_input(count_input), .capture_input_zero(cap0), .capture_input_one(cap1),
    .capture_input_two(cap2), .capture_input_three(cap3), .match_output_zero(m0), .match_output_one(m1),
    .match_output_two(m2), .match_output_three(m3), .pin_view(pin_view));

  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled, then drops for a cycle.
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    `CHK("wb_ack", 1'b1, wb_ack_o)
    if (wb_ack_o !== 1'b1) wrap_up();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] xp);
    logic [31:0] q;
    wb_xfer(1'b0, a, ZERO32, q);
    `CHK(what, xp, q)
  endtask

  // Bounded wait for a design output to go high; a miss ends the run.
  task automatic wait_hi(input string what, ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK(what, 1'b1, s)
    if (s !== 1'b1) wrap_up();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk("ctrl_rst", A_CTRL, ZERO32);
    rd_chk("plim_rst", A_PLIM, ZERO32);
    rd_chk("match3_rst", A_MATCH0 + 8'h0c, ZERO32);
    wr(8'h44, 32'hffff_ffff);
    rd_chk("unmapped", 8'h44, ZERO32);
    wr(A_PCNT, 32'h0000_0005);
    rd_chk("pcnt_ro", A_PCNT, ZERO32);
    wr(A_MATCH0 + A_STEP, 32'hdead_beef);
    rd_chk("match1_rw", A_MATCH0 + A_STEP, 32'hdead_beef);
    wr(A_EXT, 32'h0000_000a);
    @(posedge clk);
    `CHK("pins_direct", 4'ha, pin_view)
    wr(A_EXT, ZERO32);
  endtask

  // Stop match at 5: count holds, enable drops, pin 0 clears, flag reads once then clears.
  task automatic t_stop();
    wr(A_PLIM, ZERO32);
    wr(A_MATCH0, 32'h0000_0005);
    wr(A_MCTL, 32'h0000_0005);
    wr(A_EXT, 32'h0000_0011);
    wr(A_MASK, 32'h0000_0001);
    `CHK("pin0_preset", 4'h1, pin_view)
    wr(A_CTRL, 32'h0000_0001);
    wait_hi("irq_stop", irq);
    `CHK("pin0_clear", 4'h0, pin_view)
    rd_chk("count_stop", A_COUNT, 32'h0000_0005);
    rd_chk("ctrl_stop", A_CTRL, ZERO32);
    rd_chk("stat_stop", A_STAT, 32'h0000_0001);
    rd_chk("stat_read_clr", A_STAT, ZERO32);
    repeat (2) @(posedge clk);
    `CHK("irq_read_clr", 1'b0, irq)
  endtask

  // Reset match at 3 with a slow prescaler; the disable lands well before the next advance.
  task automatic t_reset();
    wr(A_CTRL, 32'h0000_0002);
    wr(A_PLIM, 32'h0000_000f);
    wr(A_MATCH0 + A_STEP, 32'h0000_0003);
    wr(A_MCTL, 32'h0000_0018);
    wr(A_EXT, 32'h0000_00c0);
    wr(A_MASK, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0001);
    wait_hi("irq_reset", irq);
    `CHK("pin1_toggle", 4'h2, pin_view)
    wr(A_CTRL, ZERO32);
    rd_chk("count_zero", A_COUNT, ZERO32);
    wr(A_STAT, 32'h0000_0002);
    repeat (2) @(posedge clk);
    `CHK("irq_w1c", 1'b0, irq)
    wr(A_EXT, ZERO32);
  endtask

  // Plain match at 4 sets pin 2; the flag stays hidden until unmasked.
  task automatic t_cont();
    logic [31:0] q;
    wr(A_CTRL, 32'h0000_0002);
    wr(A_PLIM, ZERO32);
    wr(A_MATCH0 + 8'h08, 32'h0000_0004);
    wr(A_MCTL, 32'h0000_0040);
    wr(A_EXT, 32'h0000_0200);
    wr(A_MASK, ZERO32);
    wr(A_CTRL, 32'h0000_0001);
    wait_hi("pin2_set", m2);
    repeat (3) @(posedge clk);
    `CHK("irq_masked", 1'b0, irq)
    wr(A_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk);
    `CHK("irq_unmasked", 1'b1, irq)
    wb_xfer(1'b0, A_COUNT, ZERO32, q);
    `CHK("count_runs", 1'b1, q > 32'h0000_0008)
    wr(A_STAT, 32'h0000_0004);
    wr(A_CTRL, ZERO32);
    wr(A_EXT, ZERO32);
    wr(A_MASK, ZERO32);
  endtask

  // Three pin pulses per row, counted on each edge choice, last row through the prescaler.
  task automatic t_counter();
    logic [1:0]  edg [5] = '{EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_BOTH};
    logic [31:0] lim [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h2};
    logic [31:0] cnt_x [5] = '{32'h0, 32'h3, 32'h3, 32'h6, 32'h2};
    wr(A_MCTL, ZERO32);
    for (int i = 0; i < 5; i++) begin
      wr(A_CTRL, 32'h0000_0002);
      wr(A_PLIM, lim[i]);
      wr(A_CTRL, {27'h0, edg[i], 3'b101});
      ext.pulse_count(3);
      repeat (8) @(posedge clk);
      wr(A_CTRL, ZERO32);
      rd_chk("count_ext", A_COUNT, cnt_x[i]);
    end
  endtask

  // Held count is captured on ch0 rise and ch3 fall; only ch0 may flag.
  task automatic t_capture();
    wr(A_COUNT, 32'h1234_5678);
    wr(A_CCTL, 32'h0000_0405);
    ext.set_cap(3, 1'b1);
    ext.set_cap(0, 1'b1);
    ext.set_cap(1, 1'b1);
    ext.set_cap(3, 1'b0);
    repeat (6) @(posedge clk);
    rd_chk("capt0", A_CAPT0, 32'h1234_5678);
    rd_chk("capt1_off", A_CAPT0 + A_STEP, ZERO32);
    rd_chk("capt3", A_CAPT0 + 8'h0c, 32'h1234_5678);
    rd_chk("stat_cap", A_STAT, 32'h0000_0010);
  endtask

  // Reset for four clocks, then the scenarios in turn.
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = ZERO32;
    err_total = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_stop();
    t_reset();
    t_cont();
    t_counter();
    t_capture();
    wrap_up();
  end
endmodule
